//--- common/fpmc_pkg.sv
// constants, settings layout and states of the front panel menu controller
// assumes a single 125 MHz clock domain
package fpmc_pkg;
	localparam longint CLK_HZ = 125_000_000;
	localparam longint TIMEOUT_MS = 12000;
	localparam longint TIMEOUT_CYC = TIMEOUT_MS * CLK_HZ / 1000;
	localparam longint PHASE_MS = 1000;
	localparam longint PHASE_CYC = PHASE_MS * CLK_HZ / 1000;
	localparam longint DEBOUNCE_MS = 10;
	localparam longint DEBOUNCE_CYC = DEBOUNCE_MS * CLK_HZ / 1000;
	localparam longint MUTE_MS = 50;
	localparam longint MUTE_CYC = MUTE_MS * CLK_HZ / 1000;

	localparam logic [10:0] FREQ_MIN = 11'h0FA;
	localparam logic [10:0] FREQ_MAX = 11'h3B6;
	localparam logic [10:0] GAIN_MAX = 11'h032;
	localparam logic [10:0] ADDR_MAX = 11'h01F;

	// menu order
	localparam logic [2:0] M_FREQ = 3'h0;
	localparam logic [2:0] M_GAIN = 3'h1;
	localparam logic [2:0] M_REMOTE = 3'h2;
	localparam logic [2:0] M_INVERT = 3'h3;
	localparam logic [2:0] M_EXTREF = 3'h4;
	localparam logic [2:0] M_LINK = 3'h5;
	localparam logic [2:0] M_ADDR = 3'h6;

	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_SET = 8'h04;
	localparam logic [7:0] REG_EDIT = 8'h08;
	localparam logic [7:0] REG_CTRL = 8'h0C;
	localparam logic [7:0] REG_VER = 8'h10;
	localparam int CTRL_MUTE_BIT = 0;

	typedef struct packed {
		logic [9:0] freq;
		logic [5:0] gain;
		logic remote;
		logic invert;
		logic ext_ref;
		logic link_multidrop;
		logic [4:0] addr;
	} fpmc_set_t;

	localparam fpmc_set_t SET_RST = '{freq: 10'h0FA, gain: 6'h00, remote: 1'b0,
		invert: 1'b0, ext_ref: 1'b0, link_multidrop: 1'b0, addr: 5'h00};

	typedef enum logic [2:0] {
		ST_LAMP, ST_VER, ST_SHOW, ST_NORMAL, ST_EDIT, ST_SAVE
	} fpmc_state_t;
endpackage : fpmc_pkg

//--- common/fpmc_key_if.sv
// debounced one-cycle switch press pulses
// assumes source and sink share clk
`timescale 1ns/1ns
interface fpmc_key_if;
	logic sel;
	logic left;
	logic right;
	logic up;
	logic down;
	modport src (output sel, output left, output right, output up, output down);
	modport dst (input sel, input left, input right, input up, input down);
endinterface : fpmc_key_if

//--- verilog/fpmc_keys.sv
// switch synchroniser, debouncer and press detector
// assumes raw switch pins high while pressed, asynchronous to clk
`timescale 1ns/1ns
module fpmc_keys #(
	parameter int unsigned DEB_CYC = 32'(fpmc_pkg::DEBOUNCE_CYC)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [4:0] sw_raw,
	fpmc_key_if.src k
);
	wire [4:0] press;

	for (genvar i = 0; i < 5; i++) begin : g_key
		logic m;
		logic s;
		logic db;
		logic p;
		logic [31:0] cnt;
		wire settle = (s != db) && (cnt == DEB_CYC - 1);
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				m <= 1'b0;
				s <= 1'b0;
				db <= 1'b0;
				cnt <= 32'h0;
				p <= 1'b0;
			end else begin
				m <= sw_raw[i];
				s <= m;
				cnt <= (s == db || settle) ? 32'h0 : cnt + 32'h1;
				db <= settle ? s : db;
				p <= settle && s;
			end
		end
		assign press[i] = p;
	end

	assign k.sel = press[0];
	assign k.left = press[1];
	assign k.right = press[2];
	assign k.up = press[3];
	assign k.down = press[4];

	property p_press_single;
		@(posedge clk) disable iff (!rst_n)
		press[0] |=> !press[0];
	endproperty
	a_press_single: assert property (p_press_single) else $error("press pulse too long");
endmodule : fpmc_keys

//--- verilog/fpmc_top.sv
// front panel menu controller: power-up display, seven-item menu editing, save prompt
// assumes raw switch and lock pins, an external settings store and a display driver
//
// Overview of operation
// - Seven menus in order: frequency, gain, remote, invert, ext ref, link, address.
// - Changes other than live gain take effect only via select key session closed at save prompt.
// - About twelve seconds idle in a session reverts display and abandons it.
// - Power-up shows all segments, then version, then frequency and gain still at their SET_RST values.
// - Saved settings persist across power loss and are restored on power-up.
// - Horizontal rocker moves cursor one position in the pressed direction.
// - Vertical rocker raises or lowers the frequency or gain digit under cursor.
// - Vertical rocker flips on/off settings regardless of direction.
// - Frequency applies only after yes at save; carrier muted while applied.
// - Gain applies live per digit; stored only after yes at save.
// - Gain steps by one or ten decibels depending on cursor position.
// - Gain spans zero to fifty decibels in one decibel steps.
// - Yes commits edited settings; no restores the previous settings.
// - Select key on the return marker opens the save prompt.
// - Select key off the return marker advances to the next menu.
// - Alarm lit whenever any oscillator loop reports loss of lock.
// - Mute lamp lit by mute selection or retune carrier mute, remote lamp follows remote mode.
// - Frequency spans 250 to 950 MHz in one megahertz steps.
// - Multidrop address spans 00 to 31.
`timescale 1ns/1ns
module fpmc_top #(
	parameter int NPLL = 2,
	parameter logic [15:0] FW_VERSION = 16'h0100, // arbitrary
	parameter int unsigned TIMEOUT_CYC = 32'(fpmc_pkg::TIMEOUT_CYC),
	parameter int unsigned PHASE_CYC = 32'(fpmc_pkg::PHASE_CYC),
	parameter int unsigned DEBOUNCE_CYC = 32'(fpmc_pkg::DEBOUNCE_CYC),
	parameter int unsigned MUTE_CYC = 32'(fpmc_pkg::MUTE_CYC)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sw_sel,
	input wire logic sw_left,
	input wire logic sw_right,
	input wire logic sw_up,
	input wire logic sw_down,
	input wire logic [NPLL-1:0] pll_unlock,
	input wire logic nv_valid,
	input wire fpmc_pkg::fpmc_set_t nv_rd_data,
	output logic nv_wr,
	output fpmc_pkg::fpmc_set_t nv_wr_data,
	output fpmc_pkg::fpmc_set_t app_set,
	output logic [5:0] rf_gain,
	output logic carrier_mute,
	output fpmc_pkg::fpmc_state_t disp_phase,
	output logic [2:0] disp_menu,
	output logic [2:0] disp_cursor,
	output fpmc_pkg::fpmc_set_t disp_set,
	output logic disp_yes,
	output logic [15:0] disp_version,
	output logic led_alarm,
	output logic led_mute,
	output logic led_remote,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata
);
	fpmc_key_if k();
	fpmc_pkg::fpmc_state_t st, next_st;
	fpmc_pkg::fpmc_set_t cur, next_cur, edt, next_edt;
	logic [2:0] menu, next_menu, pos, next_pos;
	logic yes, next_yes, commit, mute_sel;
	logic [31:0] tcnt, pcnt, mcnt;
	logic [NPLL-1:0] pll_m, pll_s;

	fpmc_keys #(.DEB_CYC(DEBOUNCE_CYC)) u_keys (
		.clk(clk),
		.rst_n(rst_n),
		.sw_raw({sw_down, sw_up, sw_right, sw_left, sw_sel}),
		.k(k)
	);

	wire any_key = k.sel | k.left | k.right | k.up | k.down;
	wire in_sess = (st == fpmc_pkg::ST_EDIT) || (st == fpmc_pkg::ST_SAVE);
	wire pu = (st == fpmc_pkg::ST_LAMP) || (st == fpmc_pkg::ST_VER) || (st == fpmc_pkg::ST_SHOW);
	wire ph_done = pu && (pcnt == PHASE_CYC - 1);
	wire t_out = in_sess && !any_key && (tcnt == TIMEOUT_CYC - 1);

	// digits per menu; cursor == ndig is the return marker
	wire [2:0] ndig = (menu == fpmc_pkg::M_FREQ) ? 3'h4 :
		(menu == fpmc_pkg::M_GAIN || menu == fpmc_pkg::M_ADDR) ? 3'h2 : 3'h1;
	wire at_ret = (pos == ndig);
	wire is_tog = (menu != fpmc_pkg::M_FREQ) && (menu != fpmc_pkg::M_GAIN) &&
		(menu != fpmc_pkg::M_ADDR);
	wire [2:0] didx = ndig - pos - 3'h1;
	wire [10:0] w = (didx == 3'h3) ? 11'h3E8 : (didx == 3'h2) ? 11'h064 :
		(didx == 3'h1) ? 11'h00A : 11'h001;
	wire [10:0] val = (menu == fpmc_pkg::M_FREQ) ? {1'b0, edt.freq} :
		(menu == fpmc_pkg::M_GAIN) ? {5'h00, edt.gain} : {6'h00, edt.addr};
	wire [10:0] vmax = (menu == fpmc_pkg::M_FREQ) ? fpmc_pkg::FREQ_MAX :
		(menu == fpmc_pkg::M_GAIN) ? fpmc_pkg::GAIN_MAX : fpmc_pkg::ADDR_MAX;
	wire [10:0] vmin = (menu == fpmc_pkg::M_FREQ) ? fpmc_pkg::FREQ_MIN : 11'h000;
	wire [11:0] up_sum = {1'b0, val} + {1'b0, w};
	wire [11:0] dn_lim = {1'b0, vmin} + {1'b0, w};
	wire inc_ok = up_sum <= {1'b0, vmax};
	wire dec_ok = {1'b0, val} >= dn_lim;
	wire [10:0] new_val = k.up ? up_sum[10:0] : val - w;
	wire freq_chg = commit && (edt.freq != cur.freq);

	always_comb begin
		next_st = st;
		next_menu = menu;
		next_pos = pos;
		next_yes = yes;
		next_edt = edt;
		next_cur = cur;
		commit = 1'b0;
		case (st)
			fpmc_pkg::ST_LAMP: if (ph_done) begin
				next_st = fpmc_pkg::ST_VER;
				next_cur = nv_valid ? nv_rd_data : fpmc_pkg::SET_RST;
			end
			fpmc_pkg::ST_VER: if (ph_done) begin
				next_st = fpmc_pkg::ST_SHOW;
			end
			fpmc_pkg::ST_SHOW: if (ph_done) begin
				next_st = fpmc_pkg::ST_NORMAL;
				next_edt = cur;
			end
			fpmc_pkg::ST_NORMAL: if (k.sel) begin
				next_st = fpmc_pkg::ST_EDIT;
				next_menu = fpmc_pkg::M_FREQ;
				next_pos = 3'h0;
				next_edt = cur;
			end
			fpmc_pkg::ST_EDIT: begin
				if (t_out) begin
					next_st = fpmc_pkg::ST_NORMAL;
					next_edt = cur;
				end else if (k.sel && at_ret) begin
					next_st = fpmc_pkg::ST_SAVE;
					next_yes = 1'b1;
				end else if (k.sel) begin
					next_menu = (menu == fpmc_pkg::M_ADDR) ? fpmc_pkg::M_FREQ : menu + 3'h1;
					next_pos = 3'h0;
				end else if (k.left && pos != 3'h0) begin
					next_pos = pos - 3'h1;
				end else if (k.right && !at_ret) begin
					next_pos = pos + 3'h1;
				end else if ((k.up || k.down) && !at_ret && is_tog) begin
					case (menu)
						fpmc_pkg::M_REMOTE: next_edt.remote = !edt.remote;
						fpmc_pkg::M_INVERT: next_edt.invert = !edt.invert;
						fpmc_pkg::M_EXTREF: next_edt.ext_ref = !edt.ext_ref;
						default: next_edt.link_multidrop = !edt.link_multidrop;
					endcase
				end else if ((k.up && inc_ok) || (k.down && dec_ok)) begin
					if (!at_ret) begin
						case (menu)
							fpmc_pkg::M_FREQ: next_edt.freq = new_val[9:0];
							fpmc_pkg::M_GAIN: next_edt.gain = new_val[5:0];
							default: next_edt.addr = new_val[4:0];
						endcase
					end
				end
			end
			fpmc_pkg::ST_SAVE: begin
				if (t_out) begin
					next_st = fpmc_pkg::ST_NORMAL;
					next_edt = cur;
				end else if (k.sel) begin
					next_st = fpmc_pkg::ST_NORMAL;
					commit = yes;
					next_cur = yes ? edt : cur;
					next_edt = yes ? edt : cur;
				end else if (k.left) begin
					next_yes = 1'b1;
				end else if (k.right) begin
					next_yes = 1'b0;
				end
			end
			default: next_st = fpmc_pkg::ST_LAMP;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= fpmc_pkg::ST_LAMP;
			menu <= fpmc_pkg::M_FREQ;
			pos <= 3'h0;
			yes <= 1'b1;
			cur <= fpmc_pkg::SET_RST;
			edt <= fpmc_pkg::SET_RST;
		end else begin
			st <= next_st;
			menu <= next_menu;
			pos <= next_pos;
			yes <= next_yes;
			cur <= next_cur;
			edt <= next_edt;
		end
	end

	// idle, power-up phase and mute counters
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tcnt <= 32'h0;
			pcnt <= 32'h0;
			mcnt <= 32'h0;
		end else begin
			tcnt <= (!in_sess || any_key || t_out) ? 32'h0 : tcnt + 32'h1;
			pcnt <= (!pu || ph_done) ? 32'h0 : pcnt + 32'h1;
			mcnt <= freq_chg ? MUTE_CYC : (mcnt != 32'h0) ? mcnt - 32'h1 : 32'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pll_m <= '0;
			pll_s <= '0;
		end else begin
			pll_m <= pll_unlock;
			pll_s <= pll_m;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			nv_wr <= 1'b0;
			nv_wr_data <= fpmc_pkg::SET_RST;
			app_set <= fpmc_pkg::SET_RST;
			rf_gain <= 6'h00;
			carrier_mute <= 1'b0;
			led_alarm <= 1'b0;
			led_mute <= 1'b0;
			led_remote <= 1'b0;
		end else begin
			nv_wr <= commit;
			nv_wr_data <= commit ? edt : nv_wr_data;
			app_set <= cur;
			rf_gain <= in_sess ? edt.gain : cur.gain;
			carrier_mute <= freq_chg || (mcnt > 32'h1);
			led_alarm <= |pll_s;
			led_mute <= mute_sel || carrier_mute;
			led_remote <= cur.remote;
		end
	end

	assign disp_phase = st;
	assign disp_menu = menu;
	assign disp_cursor = pos;
	assign disp_set = edt;
	assign disp_yes = yes;
	assign disp_version = FW_VERSION;

	// register port
	wire [31:0] rd_mux =
		(addr == fpmc_pkg::REG_STATUS) ? {14'h0000, led_alarm, carrier_mute, 3'h0, yes,
			1'b0, pos, 1'b0, menu, 1'b0, st} :
		(addr == fpmc_pkg::REG_SET) ? {7'h00, cur} :
		(addr == fpmc_pkg::REG_EDIT) ? {7'h00, edt} :
		(addr == fpmc_pkg::REG_CTRL) ? {31'h00000000, mute_sel} :
		(addr == fpmc_pkg::REG_VER) ? {16'h0000, FW_VERSION} : 32'h00000000;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata <= 32'h00000000;
			mute_sel <= 1'b0;
		end else begin
			rdata <= rd ? rd_mux : 32'h00000000;
			if (wr && addr == fpmc_pkg::REG_CTRL) begin
				mute_sel <= wdata[fpmc_pkg::CTRL_MUTE_BIT];
			end
		end
	end

	property p_freq_commit;
		@(posedge clk) disable iff (!rst_n)
		(st == fpmc_pkg::ST_NORMAL && $changed(cur.freq)) |->
			$past(st == fpmc_pkg::ST_SAVE && k.sel && yes);
	endproperty
	a_freq_commit: assert property (p_freq_commit) else $error("freq changed w/o save");

	property p_timeout;
		@(posedge clk) disable iff (!rst_n)
		(in_sess && !any_key && tcnt == TIMEOUT_CYC - 1) |=>
			(st == fpmc_pkg::ST_NORMAL && edt == $past(cur));
	endproperty
	a_timeout: assert property (p_timeout) else $error("idle timeout did not revert");

	property p_lamp_next;
		@(posedge clk) disable iff (!rst_n)
		st == fpmc_pkg::ST_LAMP |=> st == fpmc_pkg::ST_LAMP || st == fpmc_pkg::ST_VER;
	endproperty
	a_lamp_next: assert property (p_lamp_next) else $error("power-up order broken");

	property p_cursor_right;
		@(posedge clk) disable iff (!rst_n)
		(st == fpmc_pkg::ST_EDIT && k.right && !k.sel && !k.left && !at_ret) |=>
			pos == $past(pos) + 3'h1;
	endproperty
	a_cursor_right: assert property (p_cursor_right) else $error("cursor did not move");

	property p_toggle;
		@(posedge clk) disable iff (!rst_n)
		(st == fpmc_pkg::ST_EDIT && menu == fpmc_pkg::M_REMOTE && pos == 3'h0 && k.down &&
			!k.sel && !k.left && !k.right) |=> edt.remote != $past(edt.remote);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle did not flip");

	property p_gain_live;
		@(posedge clk) disable iff (!rst_n)
		st == fpmc_pkg::ST_EDIT ##1 st == fpmc_pkg::ST_EDIT |-> rf_gain == $past(edt.gain);
	endproperty
	a_gain_live: assert property (p_gain_live) else $error("gain not applied live");

	property p_ranges;
		@(posedge clk) disable iff (!rst_n)
		{5'h00, edt.gain} <= fpmc_pkg::GAIN_MAX && {6'h00, edt.addr} <= fpmc_pkg::ADDR_MAX &&
			(st != fpmc_pkg::ST_EDIT || ({1'b0, edt.freq} >= fpmc_pkg::FREQ_MIN &&
			{1'b0, edt.freq} <= fpmc_pkg::FREQ_MAX));
	endproperty
	a_ranges: assert property (p_ranges) else $error("setting out of range");

	property p_next_menu;
		@(posedge clk) disable iff (!rst_n)
		(st == fpmc_pkg::ST_EDIT && k.sel && !at_ret && !t_out && menu != fpmc_pkg::M_ADDR)
			|=> menu == $past(menu) + 3'h1 && pos == 3'h0;
	endproperty
	a_next_menu: assert property (p_next_menu) else $error("menu did not advance");

	property p_mute;
		@(posedge clk) disable iff (!rst_n)
		freq_chg |=> carrier_mute [*2];
	endproperty
	a_mute: assert property (p_mute) else $error("carrier not muted on retune");

	property p_alarm;
		@(posedge clk) disable iff (!rst_n)
		(|pll_s) |=> led_alarm;
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm lamp missed lock loss");
endmodule : fpmc_top

//--- bench/fpmc_panel_model.sv
// operator switches and settings store facing the menu controller
// assumes raw switch pins high while pressed, all on clk
`timescale 1ns/1ns
module fpmc_panel_model (
	input wire logic clk,
	input wire logic nv_wr,
	input wire fpmc_pkg::fpmc_set_t nv_wr_data,
	output logic [4:0] sw,
	output logic nv_valid,
	output fpmc_pkg::fpmc_set_t nv_rd_data
);
	// store contents start from preload, so no start-up race with it
	initial begin
		sw = 5'h00;
	end

	// store keeps the last written settings across resets
	always @(posedge clk) begin
		if (nv_wr === 1'b1) begin
			nv_rd_data <= nv_wr_data;
			nv_valid <= 1'b1;
		end
	end

	task preload(input logic [9:0] f, input logic [5:0] g);
		nv_rd_data = fpmc_pkg::SET_RST;
		nv_rd_data.freq = f;
		nv_rd_data.gain = g;
		nv_valid = 1'b1;
	endtask : preload

	// held well past debounce, released as long
	task press(input int k);
		@(posedge clk);
		sw[k] <= 1'b1;
		repeat (10) @(posedge clk);
		sw[k] <= 1'b0;
		repeat (10) @(posedge clk);
		#1;
	endtask : press
endmodule : fpmc_panel_model

//--- bench/front_panel_menu_controller_test.sv
// self-checking bench for the front panel menu controller
// assumes shortened timing parameters and the panel model as far side
`timescale 1ns/1ns
module front_panel_menu_controller_test;
	localparam int SEL = 0, LF = 1, RT = 2, UP = 3, DN = 4;
	localparam int TO = 200;
	logic clk, rst_n, wr, rd, nv_valid, nv_wr, carrier_mute, disp_yes;
	logic led_alarm, led_mute, led_remote;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, rv;
	logic [1:0] pll_unlock;
	logic [4:0] sw;
	logic [5:0] rf_gain;
	logic [2:0] disp_menu, disp_cursor;
	logic [15:0] disp_version;
	fpmc_pkg::fpmc_set_t nv_rd_data, nv_wr_data, app_set, disp_set;
	fpmc_pkg::fpmc_state_t disp_phase;
	int miscompares, n_compared, cycles, n_wr;

	fpmc_top #(.NPLL(2), .TIMEOUT_CYC(TO), .PHASE_CYC(10), .DEBOUNCE_CYC(4),
		.MUTE_CYC(40)) i_dut (.clk(clk), .rst_n(rst_n), .sw_sel(sw[SEL]),
		.sw_left(sw[LF]), .sw_right(sw[RT]), .sw_up(sw[UP]), .sw_down(sw[DN]),
		.pll_unlock(pll_unlock), .nv_valid(nv_valid), .nv_rd_data(nv_rd_data),
		.nv_wr(nv_wr), .nv_wr_data(nv_wr_data), .app_set(app_set), .rf_gain(rf_gain),
		.carrier_mute(carrier_mute), .disp_phase(disp_phase), .disp_menu(disp_menu),
		.disp_cursor(disp_cursor), .disp_set(disp_set), .disp_yes(disp_yes),
		.disp_version(disp_version), .led_alarm(led_alarm), .led_mute(led_mute),
		.led_remote(led_remote), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata));

	fpmc_panel_model i_panel (.clk(clk), .nv_wr(nv_wr), .nv_wr_data(nv_wr_data),
		.sw(sw), .nv_valid(nv_valid), .nv_rd_data(nv_rd_data));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task conclude();
		if (miscompares == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (nv_wr === 1'b1) begin
			n_wr <= n_wr + 1;
		end
		if (cycles >= 6000) begin
			miscompares = miscompares + 1;
			conclude();
		end
	end

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	task reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr

	task reg_rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		rv = rdata;
	endtask : reg_rd

	task wait_change();
		fpmc_pkg::fpmc_state_t p;
		p = disp_phase;
		for (int i = 0; i < 100 && disp_phase === p; i++) begin
			@(posedge clk);
			#1;
		end
	endtask : wait_change

	task t_powerup(input logic [9:0] f, input logic rem);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk("phase lamp", fpmc_pkg::ST_LAMP, disp_phase);
		wait_change();
		chk("phase version", fpmc_pkg::ST_VER, disp_phase);
		chk("version", 32'h0100, disp_version);
		wait_change();
		chk("phase show", fpmc_pkg::ST_SHOW, disp_phase);
		wait_change();
		chk("phase normal", fpmc_pkg::ST_NORMAL, disp_phase);
		chk("restored freq", f, app_set.freq);
		chk("restored gain", 32'h14, rf_gain);
		chk("restored remote", rem, app_set.remote);
		chk("remote lamp", rem, led_remote);
	endtask : t_powerup

	task goto_marker();
		logic [2:0] c;
		for (int i = 0; i < 5; i++) begin
			c = disp_cursor;
			i_panel.press(RT);
			if (disp_cursor === c) break;
		end
	endtask : goto_marker

	task t_freq();
		i_panel.press(SEL);
		chk("edit phase", fpmc_pkg::ST_EDIT, disp_phase);
		chk("first menu", 32'h0, disp_menu);
		i_panel.press(RT);
		chk("cursor right", 32'h1, disp_cursor);
		i_panel.press(LF);
		chk("cursor left", 32'h0, disp_cursor);
		i_panel.press(LF);
		chk("cursor left edge", 32'h0, disp_cursor);
		i_panel.press(RT);
		i_panel.press(UP);
		chk("edited freq", 32'h2BC, disp_set.freq);
		chk("freq not applied", 32'h258, app_set.freq);
		goto_marker();
		chk("marker", 32'h4, disp_cursor);
		i_panel.press(SEL);
		chk("save phase", fpmc_pkg::ST_SAVE, disp_phase);
		chk("yes default", 32'h1, disp_yes);
		i_panel.press(SEL);
		chk("normal", fpmc_pkg::ST_NORMAL, disp_phase);
		chk("applied freq", 32'h2BC, app_set.freq);
		chk("stored", 32'h1, n_wr);
		chk("carrier mute", 32'h1, carrier_mute);
	endtask : t_freq

	task t_gain();
		i_panel.press(SEL);
		i_panel.press(SEL);
		chk("gain menu", 32'h1, disp_menu);
		chk("mute over", 32'h0, carrier_mute);
		i_panel.press(UP);
		chk("live gain", 32'h1E, rf_gain);
		chk("saved gain", 32'h14, app_set.gain);
		i_panel.press(UP);
		i_panel.press(UP);
		chk("gain max", 32'h32, rf_gain);
		i_panel.press(UP);
		chk("gain clamp", 32'h32, rf_gain);
		i_panel.press(RT);
		i_panel.press(DN);
		chk("gain units", 32'h31, rf_gain);
		goto_marker();
		i_panel.press(SEL);
		i_panel.press(RT);
		chk("no chosen", 32'h0, disp_yes);
		i_panel.press(SEL);
		chk("gain reverted", 32'h14, rf_gain);
		chk("gain edit reverted", 32'h14, disp_set.gain);
		chk("no store", 32'h1, n_wr);
	endtask : t_gain

	task t_toggle();
		i_panel.press(SEL);
		for (int i = 1; i < 10; i++) begin
			i_panel.press(SEL);
			chk("menu order", i % 7, disp_menu);
		end
		i_panel.press(UP);
		chk("flip up", 32'h1, disp_set.remote);
		i_panel.press(UP);
		chk("flip up again", 32'h0, disp_set.remote);
		i_panel.press(DN);
		chk("flip down", 32'h1, disp_set.remote);
		repeat (TO + 40) @(posedge clk);
		#1;
		chk("timeout normal", fpmc_pkg::ST_NORMAL, disp_phase);
		chk("abandoned remote", 32'h0, app_set.remote);
		chk("remote lamp off", 32'h0, led_remote);
		i_panel.press(SEL);
		i_panel.press(SEL);
		i_panel.press(SEL);
		i_panel.press(DN);
		goto_marker();
		i_panel.press(SEL);
		i_panel.press(SEL);
		chk("remote applied", 32'h1, app_set.remote);
		chk("remote lamp on", 32'h1, led_remote);
	endtask : t_toggle

	task t_regs();
		pll_unlock <= 2'h2;
		for (int i = 0; i < 10 && led_alarm !== 1'b1; i++) @(posedge clk);
		#1;
		chk("alarm", 32'h1, led_alarm);
		reg_rd(fpmc_pkg::REG_STATUS);
		chk("status alarm", 32'h1, rv[17]);
		pll_unlock <= 2'h0;
		for (int i = 0; i < 10 && led_alarm !== 1'b0; i++) @(posedge clk);
		#1;
		chk("alarm clear", 32'h0, led_alarm);
		reg_wr(fpmc_pkg::REG_CTRL, 32'h1);
		@(posedge clk);
		#1;
		chk("mute lamp", 32'h1, led_mute);
		reg_rd(fpmc_pkg::REG_CTRL);
		chk("ctrl", 32'h1, rv);
		reg_wr(fpmc_pkg::REG_CTRL, 32'h0);
		@(posedge clk);
		#1;
		chk("mute lamp off", 32'h0, led_mute);
		reg_rd(fpmc_pkg::REG_VER);
		chk("version reg", 32'h0100, rv);
		reg_rd(8'h40);
		chk("unmapped", 32'h0, rv);
		reg_rd(fpmc_pkg::REG_SET);
		chk("applied reg", 32'h015E2900, rv);
	endtask : t_regs

	task t_addr();
		i_panel.press(SEL);
		i_panel.press(UP);
		chk("freq clamp", 32'h2BC, disp_set.freq);
		repeat (3) i_panel.press(SEL);
		i_panel.press(UP);
		chk("invert flip", 32'h1, disp_set.invert);
		repeat (3) i_panel.press(SEL);
		chk("addr menu", 32'h6, disp_menu);
		repeat (4) i_panel.press(UP);
		chk("addr tens clamp", 32'h1E, disp_set.addr);
		i_panel.press(RT);
		repeat (2) i_panel.press(UP);
		chk("addr max", 32'h1F, disp_set.addr);
		goto_marker();
		i_panel.press(SEL);
		i_panel.press(SEL);
		chk("applied addr", 32'h1F, app_set.addr);
		chk("applied invert", 32'h1, app_set.invert);
		chk("stored again", 32'h3, n_wr);
	endtask : t_addr

	initial begin
		miscompares = 0;
		n_compared = 0;
		cycles = 0;
		n_wr = 0;
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		pll_unlock = 2'h0;
		i_panel.preload(10'h258, 6'h14);
		t_powerup(10'h258, 1'b0);
		t_freq();
		t_gain();
		t_toggle();
		t_powerup(10'h2BC, 1'b1);
		t_regs();
		t_addr();
		conclude();
	end
endmodule : front_panel_menu_controller_test
